// [vimss_ctrl.sv]
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// RULE1: port change requests 44..50 share vector 33, flag bits 12..18, word 8 priority
// RULE2: parallel port event and error share vector 34, word 8 bits 20:18
// RULE3: second SPI requests 53..55 share vector 35, word 8 bits 28:26
// RULE4: second UART requests 56..58 share vector 36, word 9 bits 4:2
// RULE5: second I2C events 59..61 share vector 37, word 9 bits 12:10
// RULE6: third UART on vector 38, transmit flag moves to bit 0 of word c
// RULE7: fourth UART requests on vector 39, flags c bits 1..3
// RULE8: fifth UART on vector 40, absent on the small variant
// RULE9: charge time event on vector 41, absent on the small variant
// RULE10: four DMA channels own vectors 42..45 and are non-persistent
// RULE11: comparator three vector 46 non-persistent, CAN vector 47 persistent
// RULE12: third SPI requests 78..80 share vector 48, word 12 bits 4:2
// RULE13: fourth SPI on vector 49, absent on the small variant
// RULE14: equal priority and subpriority resolve toward the lower IRQ number
// RULE15: status bits 10:8 hold the level last presented to the core
// RULE16: status bits 5:0 hold the vector presented to the core
// RULE17: software trusts the status fields only in single vector mode
// RULE18: unused status bits read zero, status resets to zero
// RULE19: proximity timer loads the reload word on an event, reload resets zero
// RULE20: only flagged and enabled sources compete: priority, subpriority, order
// RULE21: persistent flags re-set while asserted, others only on a new edge
module vimss_ctrl #(
  parameter bit LARGE_PINS = 1'b1
) (
  input wire logic clock,
  input wire logic srst,
  input wire vimss_pkg::vimss_wb_req_t wb_req,
  output vimss_pkg::vimss_irq_t irq_out,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  output logic prox_expire,
  input wire logic [vimss_pkg::NUM_SRC-1:0] src_req
);
  import vimss_pkg::*;

  // ==========================================================
  // state
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] req_q;
  logic [31:0] ipc [NUM_IPC];
  logic [31:0] reload;
  logic [31:0] prox_count;
  logic [2:0] presented_priority_level;
  logic [5:0] presented_vector;

  // ==========================================================
  // per-source constants
  logic [NUM_SRC-1:0] persist_mask;
  logic [NUM_SRC-1:0] present_mask;
  logic [5:0] vec_of [NUM_SRC];

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    assign vec_of[s] = src_vector(s); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE7
    assign persist_mask[s] = src_persistent(s); // RULE10 RULE11
    // the small variant has no pins for these peripherals
    assign present_mask[s] = LARGE_PINS || !src_large_only(s); // RULE8 RULE9 RULE13
  end

  // ==========================================================
  // bus decode
  wire bus_req = wb_req.cyc && wb_req.stb && !wb_ack;
  wire wr = bus_req && wb_req.we;
  wire wr_reload = wr && wb_req.adr == ADR_RELOAD;
  wire wr_flag_b = wr && wb_req.adr == ADR_FLAG_B;
  wire wr_flag_c = wr && wb_req.adr == ADR_FLAG_C;
  wire wr_en_b = wr && wb_req.adr == ADR_EN_B;
  wire wr_en_c = wr && wb_req.adr == ADR_EN_C;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // flag words: b carries sources 0..19 at bits 12..31, c carries 20..39 at bits 0..19
  wire [31:0] flag_word_b = {flags[FLAG_B_SRCS-1:0], 12'h000};
  wire [31:0] flag_word_c = {12'h000, flags[NUM_SRC-1:FLAG_B_SRCS]}; // RULE6
  wire [31:0] enable_word_b = {enables[FLAG_B_SRCS-1:0], 12'h000};
  wire [31:0] enable_word_c = {12'h000, enables[NUM_SRC-1:FLAG_B_SRCS]};
  wire [31:0] interrupt_status = {21'h000000, presented_priority_level, 2'h0,
                                  presented_vector}; // RULE18

  wire [31:0] m_flag_b = merge(flag_word_b, wb_req.dat, wb_req.sel);
  wire [31:0] m_flag_c = merge(flag_word_c, wb_req.dat, wb_req.sel);
  wire [31:0] m_en_b = merge(enable_word_b, wb_req.dat, wb_req.sel);
  wire [31:0] m_en_c = merge(enable_word_c, wb_req.dat, wb_req.sel);
  wire [31:0] m_reload = merge(reload, wb_req.dat, wb_req.sel);

  wire adr_ipc = wb_req.adr >= ADR_PRIORITY_WORD_8 && wb_req.adr <= ADR_PRIORITY_WORD_12 && wb_req.adr[1:0] == 2'h0;
  wire [2:0] ipc_idx = 3'((wb_req.adr - ADR_PRIORITY_WORD_8) >> 2);

  logic [31:0] rd_data;
  always_comb begin
    unique case (wb_req.adr)
      ADR_STATUS: rd_data = interrupt_status;
      ADR_RELOAD: rd_data = reload; // RULE19
      ADR_FLAG_B: rd_data = flag_word_b;
      ADR_FLAG_C: rd_data = flag_word_c;
      ADR_EN_B: rd_data = enable_word_b;
      ADR_EN_C: rd_data = enable_word_c;
      default: rd_data = adr_ipc ? ipc[ipc_idx] : WORD_RESET;
    endcase
  end

  // ==========================================================
  // flag capture
  wire [NUM_SRC-1:0] edge_set = src_req & ~req_q;
  // level sources keep re-setting, pulses only on a fresh edge
  wire [NUM_SRC-1:0] set_vec = (persist_mask & src_req | ~persist_mask & edge_set)
                               & present_mask; // RULE21
  wire [NUM_SRC-1:0] sw_flags = {m_flag_c[FLAG_B_SRCS-1:0], m_flag_b[31:FLAG_B_LSB]};
  wire [NUM_SRC-1:0] sw_en = {m_en_c[FLAG_B_SRCS-1:0], m_en_b[31:FLAG_B_LSB]};
  logic [NUM_SRC-1:0] next_flags;
  logic [NUM_SRC-1:0] next_enables;
  always_comb begin
    next_flags = flags;
    next_enables = enables;
    if (wr_flag_b) next_flags[FLAG_B_SRCS-1:0] = sw_flags[FLAG_B_SRCS-1:0];
    if (wr_flag_c) next_flags[NUM_SRC-1:FLAG_B_SRCS] = sw_flags[NUM_SRC-1:FLAG_B_SRCS];
    if (wr_en_b) next_enables[FLAG_B_SRCS-1:0] = sw_en[FLAG_B_SRCS-1:0];
    if (wr_en_c) next_enables[NUM_SRC-1:FLAG_B_SRCS] = sw_en[NUM_SRC-1:FLAG_B_SRCS];
    // hardware set wins over a software clear in the same cycle
    next_flags = (next_flags | set_vec) & present_mask; // RULE21
    next_enables = next_enables & present_mask;
  end

  // ==========================================================
  // arbitration
  wire [NUM_SRC-1:0] pending = flags & enables; // RULE20

  // priority 0 means the vector is disabled, so it never competes
  function automatic logic [4:0] vec_key(input logic [5:0] v);
    logic [31:0] w;
    logic [7:0] f;
    w = ipc[3'(v[5:2] - 4'(IPC_FIRST))];
    f = w[v[1:0]*8 +: 8];
    return f[4:0]; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE7 RULE12 RULE13
  endfunction : vec_key

  // always_comb sees the priority words read inside the function, an assign would not
  logic [4:0] key_of [NUM_SRC];
  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) key_of[s] = vec_key(vec_of[s]);
  end

  logic win_valid;
  logic [4:0] win_key;
  logic [5:0] win_vec;
  always_comb begin
    win_valid = 1'b0;
    win_key = 5'h00;
    win_vec = 6'h00;
    // walking down with >= lets the lower IRQ take a tie
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (pending[s] && key_of[s][4:2] != 3'h0 &&
          (!win_valid || key_of[s] >= win_key)) begin // RULE14 RULE20
        win_valid = 1'b1;
        win_key = key_of[s];
        win_vec = vec_of[s];
      end
    end
  end

  // ==========================================================
  // proximity timer
  wire prox_trigger = |(set_vec & enables); // RULE19
  logic [31:0] next_prox;
  always_comb begin
    if (prox_trigger) next_prox = reload; // RULE19
    else if (prox_count != WORD_RESET) next_prox = prox_count - 32'h1;
    else next_prox = prox_count;
  end
  wire next_expire = !prox_trigger && prox_count == 32'h1;

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (srst) begin
      flags <= '0;
      enables <= '0;
      req_q <= '0;
      reload <= WORD_RESET; // RULE19
      prox_count <= WORD_RESET;
      prox_expire <= 1'b0;
      presented_priority_level <= 3'h0; // RULE18
      presented_vector <= 6'h00;
      irq_out <= '0;
      wb_ack <= 1'b0;
      wb_dat_o <= WORD_RESET;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      req_q <= src_req;
      prox_count <= next_prox;
      prox_expire <= next_expire;
      if (wr_reload) reload <= m_reload; // RULE19
      irq_out <= '{req: win_valid, vector: win_vec, level: win_key[4:2]}; // RULE16
      if (win_valid) begin
        presented_priority_level <= win_key[4:2]; // RULE15
        presented_vector <= win_vec; // RULE16
      end
      wb_ack <= bus_req;
      if (bus_req) wb_dat_o <= rd_data;
    end
  end

  for (genvar i = 0; i < NUM_IPC; i++) begin : g_ipc
    wire wr_ipc = wr && adr_ipc && ipc_idx == 3'(i);
    always_ff @(posedge clock) begin
      if (srst) ipc[i] <= WORD_RESET;
      else if (wr_ipc) ipc[i] <= merge(ipc[i], wb_req.dat, wb_req.sel);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_status_zero_bits: // RULE18
    assert property (wb_ack && $past(wb_req.adr) == ADR_STATUS |->
                     wb_dat_o[31:11] == 21'h0 && wb_dat_o[7:6] == 2'h0)
    else $error("status reserved bits not zero");

  a_port_change_vec: // RULE1
    assert property (pending == 40'h1 && key_of[0][4:2] != 3'h0 |=>
                     irq_out.req && irq_out.vector == 6'h21)
    else $error("port change source not on vector 33");

  a_uart3_tx_vec: // RULE6
    assert property (pending == (40'h1 << 20) && key_of[20][4:2] != 3'h0 && !wr_flag_c |=>
                     irq_out.vector == 6'h26 && flag_word_c[0])
    else $error("third uart transmit not on vector 38");

  a_dma_own_vec: // RULE10
    assert property (pending == (40'h1 << 31) && key_of[31][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h2D)
    else $error("dma three not on vector 45");

  a_small_absent: // RULE8
    assert property (!LARGE_PINS |-> flags[27:24] == 4'h0 && flags[39:37] == 3'h0)
    else $error("absent source flagged");

  a_persist_reset: // RULE21
    assert property (src_req[33] |=> flags[33])
    else $error("persistent flag not re-set");

  a_dma_stays_clear: // RULE21
    assert property (!flags[28] && !edge_set[28] && !wr_flag_c |=> !flags[28])
    else $error("non-persistent flag set without an edge");

  a_level_tracks: // RULE15
    assert property (irq_out.req |-> presented_priority_level == irq_out.level &&
                     presented_vector == irq_out.vector)
    else $error("status does not follow presented interrupt");

  a_forward_gate: // RULE20
    assert property (irq_out.req |-> $past(pending) != '0)
    else $error("request without a pending source");

  a_prox_load: // RULE19
    assert property (prox_trigger |=> prox_count == $past(reload))
    else $error("proximity timer missed its reload");

  a_reload_write: // RULE19
    assert property (wr_reload && wb_req.sel == 4'hF ##1 !wr_reload [*2] |->
                     reload == $past(wb_req.dat, 2))
    else $error("reload write lost");

  a_tie_low_irq: // RULE14
    assert property (pending == 40'h280 && key_of[7] == key_of[9] &&
                     key_of[7][4:2] != 3'h0 |=> irq_out.vector == 6'h22)
    else $error("tie not resolved toward lower irq");

  a_pport_vec: // RULE2
    assert property (pending == (40'h1 << 7) && key_of[7][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h22)
    else $error("parallel port source not on vector 34");

  a_spi2_vec: // RULE3
    assert property (pending == (40'h1 << 9) && key_of[9][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h23)
    else $error("second spi source not on vector 35");

  a_uart2_vec: // RULE4
    assert property (pending == (40'h1 << 12) && key_of[12][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h24)
    else $error("second uart source not on vector 36");

  a_i2c2_vec: // RULE5
    assert property (pending == (40'h1 << 15) && key_of[15][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h25)
    else $error("second i2c source not on vector 37");

  a_uart4_vec: // RULE7
    assert property (pending == (40'h1 << 21) && key_of[21][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h27)
    else $error("fourth uart source not on vector 39");

  a_uart5_vec: // RULE8
    assert property (pending == (40'h1 << 24) && key_of[24][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h28)
    else $error("fifth uart source not on vector 40");

  a_charge_time_vec: // RULE9
    assert property (pending == (40'h1 << 27) && key_of[27][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h29)
    else $error("charge time source not on vector 41");

  a_comparator_vec: // RULE11
    assert property (pending == (40'h1 << 32) && key_of[32][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h2E)
    else $error("comparator three not on vector 46");

  a_spi3_vec: // RULE12
    assert property (pending == (40'h1 << 34) && key_of[34][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h30)
    else $error("third spi source not on vector 48");

  a_spi4_vec: // RULE13
    assert property (pending == (40'h1 << 39) && key_of[39][4:2] != 3'h0 |=>
                     irq_out.vector == 6'h31)
    else $error("fourth spi source not on vector 49");

  a_small_enables: // RULE8
    assert property (!LARGE_PINS |-> enables[27:24] == 4'h0 && enables[39:37] == 3'h0)
    else $error("absent source enabled");

  a_req_needs_level: // RULE20
    assert property (irq_out.req |-> irq_out.level != 3'h0)
    else $error("request presented with priority zero");

  a_idle_no_req: // RULE20
    assert property (pending == '0 |=> !irq_out.req)
    else $error("request without flagged and enabled source");

  a_status_hold: // RULE15
    assert property (!win_valid |=> presented_vector == $past(presented_vector) &&
                     presented_priority_level == $past(presented_priority_level))
    else $error("status changed with nothing presented");

  a_status_readback: // RULE16
    assert property (bus_req && !wb_req.we && wb_req.adr == ADR_STATUS |=>
                     wb_dat_o[5:0] == $past(presented_vector) &&
                     wb_dat_o[10:8] == $past(presented_priority_level))
    else $error("status read does not show presented fields");

  a_reload_readback: // RULE19
    assert property (bus_req && !wb_req.we && wb_req.adr == ADR_RELOAD |=>
                     wb_dat_o == $past(reload))
    else $error("reload read wrong");

  a_expire_pulse: // RULE19
    assert property (prox_expire |=> !prox_expire)
    else $error("proximity expiry longer than one cycle");

  a_ack_follows_req:
    assert property (bus_req |=> wb_ack)
    else $error("bus request not acknowledged");

  a_no_ack_idle:
    assert property (!bus_req |=> !wb_ack)
    else $error("acknowledge without request");

endmodule : vimss_ctrl

// [vimss_pkg.sv]
package vimss_pkg;

  // ==========================================================
  // sizes and reset values
  localparam int NUM_SRC = 40;
  localparam int FIRST_IRQ = 44;
  localparam int FLAG_B_LSB = 12;
  localparam int FLAG_B_SRCS = 20;
  localparam int IPC_FIRST = 8;
  localparam int NUM_IPC = 5;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_RELOAD = 8'h04;
  localparam logic [7:0] ADR_FLAG_B = 8'h08;
  localparam logic [7:0] ADR_FLAG_C = 8'h0C;
  localparam logic [7:0] ADR_EN_B = 8'h10;
  localparam logic [7:0] ADR_EN_C = 8'h14;
  localparam logic [7:0] ADR_PRIORITY_WORD_8 = 8'h18;
  localparam logic [7:0] ADR_PRIORITY_WORD_12 = 8'h28;

  // ==========================================================
  // status register field positions
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_VEC_LSB = 0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } vimss_wb_req_t;

  typedef struct packed {
    logic req;
    logic [5:0] vector;
    logic [2:0] level;
  } vimss_irq_t;

  // ==========================================================
  // source decoding, index s = irq - FIRST_IRQ
  function automatic logic [5:0] src_vector(input int s);
    if (s < 7) return 6'h21;
    else if (s < 9) return 6'h22;
    else if (s < 12) return 6'h23;
    else if (s < 15) return 6'h24;
    else if (s < 18) return 6'h25;
    else if (s < 21) return 6'h26;
    else if (s < 24) return 6'h27;
    else if (s < 27) return 6'h28;
    else if (s < 28) return 6'h29;
    else if (s < 32) return 6'(6'h2A + s - 28);
    else if (s < 33) return 6'h2E;
    else if (s < 34) return 6'h2F;
    else if (s < 37) return 6'h30;
    else return 6'h31;
  endfunction : src_vector

  function automatic logic src_persistent(input int s);
    return !(s >= 28 && s <= 32);
  endfunction : src_persistent

  function automatic logic src_large_only(input int s);
    return (s >= 24 && s <= 27) || (s >= 37);
  endfunction : src_large_only

endpackage : vimss_pkg

// [vimss_core_model.sv]
`timescale 1ns/1ps

// ==========================================================
// core side: latches what the controller presents when a request starts
module vimss_core_model (
  input wire logic clock,
  input wire logic srst,
  input wire vimss_pkg::vimss_irq_t irq_in,
  output logic [5:0] seen_vec,
  output logic [2:0] seen_lvl
);
  import vimss_pkg::*;
  logic prev_req;

  // only a new request is taken, as a single vector core would take it
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_req <= 1'h0;
      seen_vec <= 6'h00;
      seen_lvl <= 3'h0;
    end else begin
      prev_req <= irq_in.req;
      if (irq_in.req && !prev_req) begin
        seen_vec <= irq_in.vector;
        seen_lvl <= irq_in.level;
      end
    end
  end
endmodule : vimss_core_model

// [vimss_ctrl_tb.sv]
`timescale 1ns/1ps

module vimss_ctrl_tb;
  import vimss_pkg::*;
  logic clock, srst, wb_ack, prox_expire;
  vimss_wb_req_t wb_req;
  vimss_irq_t irq_out;
  logic [31:0] wb_dat_o, rd;
  logic [NUM_SRC-1:0] src_req;
  logic [5:0] seen_vec;
  logic [2:0] seen_lvl;
  int err_count, tests_run, n;
  int irqs[18] = '{44, 50, 51, 52, 53, 56, 59, 62, 64, 65, 68, 71, 72, 75, 76, 77, 78, 83};
  int vecs[18] = '{33, 33, 34, 34, 35, 36, 37, 38, 38, 39, 40, 41, 42, 45, 46, 47, 48, 49};

  vimss_ctrl DUT (.clock(clock), .srst(srst), .wb_req(wb_req), .irq_out(irq_out),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .prox_expire(prox_expire), .src_req(src_req));
  vimss_core_model core (.clock(clock), .srst(srst), .irq_in(irq_out),
    .seen_vec(seen_vec), .seen_lvl(seen_lvl));

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // one classic cycle; the slave decides when ack comes
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, dat: d, sel: 4'hF};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'h1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20) chk(32'h0, 32'h1, "no ack");
    wb_req <= '0;
  endtask : wb

  task clr;
    src_req <= '0;
    wb(1'h1, ADR_FLAG_B, 32'h0);
    wb(1'h1, ADR_FLAG_C, 32'h0);
  endtask : clr

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // tests
  initial begin
    srst = 1'h1;
    wb_req = '0;
    src_req = '0;
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    srst <= 1'h0;
    wb(1'h0, ADR_STATUS, 32'h0); chk(rd, WORD_RESET, "status reset");
    wb(1'h0, ADR_RELOAD, 32'h0); chk(rd, WORD_RESET, "reload reset");
    wb(1'h1, ADR_STATUS, 32'hFFFF_FFFF);
    wb(1'h0, ADR_STATUS, 32'h0); chk(rd, 32'h0, "status write");
    wb(1'h0, 8'h80, 32'h0); chk(rd, 32'h0, "unmapped");
    wb(1'h1, ADR_RELOAD, 32'hA5C3_0F96);
    wb(1'h0, ADR_RELOAD, 32'h0); chk(rd, 32'hA5C3_0F96, "reload rw");
    $display("test registers done");

    for (int i = 0; i < 5; i++) wb(1'h1, ADR_PRIORITY_WORD_8 + 8'(4 * i), 32'h0404_0404);
    wb(1'h1, ADR_EN_B, 32'hFFFF_F000);
    wb(1'h1, ADR_EN_C, 32'h000F_FFFF);
    for (int i = 0; i < 18; i++) begin
      src_req[irqs[i] - FIRST_IRQ] <= 1'h1;
      repeat (4) @(posedge clock);
      chk(32'(seen_vec), 32'(vecs[i]), "vector");
      chk(32'(seen_lvl), 32'h1, "level");
      wb(1'h0, ADR_STATUS, 32'h0);
      chk(rd, {21'h0, 3'h1, 2'h0, 6'(vecs[i])}, "status");
      clr();
    end
    $display("test vector map done");

    // held level sources come back after a clear, a held edge source does not
    src_req <= 40'h00_1014_0000;
    repeat (3) @(posedge clock);
    wb(1'h1, ADR_FLAG_B, 32'h0);
    wb(1'h1, ADR_FLAG_C, 32'h0);
    wb(1'h0, ADR_FLAG_B, 32'h0); chk(rd, 32'h4000_0000, "flag b");
    wb(1'h0, ADR_FLAG_C, 32'h0); chk(rd, 32'h0000_0001, "flag c");
    clr();
    $display("test persistence done");

    src_req <= 40'h00_0000_0280;
    repeat (4) @(posedge clock);
    chk(32'(irq_out.vector), 32'h22, "tie");
    wb(1'h1, ADR_PRIORITY_WORD_8, 32'h0804_0404);
    repeat (3) @(posedge clock);
    chk({26'h0, irq_out.level, irq_out.vector[2:0]}, 32'h13, "priority");
    wb(1'h1, ADR_EN_B, 32'hFFDF_F000);
    repeat (3) @(posedge clock);
    chk(32'(irq_out.vector), 32'h22, "enable");
    clr();
    $display("test arbitration done");

    wb(1'h1, ADR_RELOAD, 32'h0000_0005);
    src_req[28] <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (prox_expire !== 1'h1 && n < 30);
    chk(32'(n >= 5 && n <= 8), 32'h1, "proximity");
    clr();
    $display("test proximity done");
    report_and_stop();
  end

  initial begin
    #100000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : vimss_ctrl_tb
